// file: pkg/bfcu_pkg.sv
// Contract
// - opcode bits 11..8, operand bits 2..0
// - 0010/0011 save read/write into reread/rewrite
// - 0100/0101 restore read/write from saved pointers
// - 1000/1001 increment secondary read/write pointer
// - reset 001 reverse, 011 both, 000/101/110 nop
// - reset 010 clears forward pointers only
// - reset 100 clears dma request logic only
// - reset 111 clears pointers, dma, config
// - hardware reset also clears format, direction
// - opcode 0001 selects configuration register
// - opcode 0110 sets dma direction, peripheral only
// - registers 0-3 hold 10-bit offsets, reset zero
// - register 4 routes flags, default 6420
// - control bit 0 selects strobe style
// - control bits 2,3 redefine full/empty
// - bits 4,5 request/acknowledge polarity
// - dma clock from external, bit 9 divides
// - bit 8 strobe width one or two
// - bits 6,7 request-to-acknowledge delay 2-5
// - bit 10 selects secondary port mode
// - bit 10 high means peripheral mode
// - register 7 sets pin directions
// - register 6 drives outputs, reads inputs
// - status read returns flags and direction
package bfcu_pkg;
    localparam int PTR_W = 10;
    localparam logic [3:0] OP_RESET = 4'h0;
    localparam logic [3:0] OP_SEL_CFG = 4'h1;
    localparam logic [3:0] OP_SAVE_RD = 4'h2;
    localparam logic [3:0] OP_SAVE_WR = 4'h3;
    localparam logic [3:0] OP_LOAD_RD = 4'h4;
    localparam logic [3:0] OP_LOAD_WR = 4'h5;
    localparam logic [3:0] OP_DMA_DIR = 4'h6;
    localparam logic [3:0] OP_INC_RD = 4'h8;
    localparam logic [3:0] OP_INC_WR = 4'h9;
    localparam logic [2:0] RST_REV = 3'h1;
    localparam logic [2:0] RST_FWD = 3'h2;
    localparam logic [2:0] RST_BOTH = 3'h3;
    localparam logic [2:0] RST_DMA = 3'h4;
    localparam logic [2:0] RST_ALL = 3'h7;
    localparam int OPC_LSB = 8;
    localparam logic [15:0] CFG4_RESET = 16'h6420;
    localparam logic [15:0] CFG_RESET = 16'h0000;
    localparam int GC_STROBE = 0;
    localparam int GC_FULL_DEF = 2;
    localparam int GC_EMPTY_DEF = 3;
    localparam int GC_REQ_POL = 4;
    localparam int GC_ACK_POL = 5;
    localparam int GC_DLY_LSB = 6;
    localparam int GC_STB_LEN = 8;
    localparam int GC_CLK_DIV = 9;
    localparam int GC_PERIPH = 10;
    localparam logic [2:0] DLY_BASE = 3'h2;
    localparam int ST_DIR = 3;
    localparam int PIO_N = 6;
    typedef enum logic [1:0] {
        DMA_IDLE = 2'b00,
        DMA_WAIT = 2'b01,
        DMA_STROBE = 2'b10
    } bfcu_dma_t;
endpackage

// file: design/bfcu_sync.sv
`timescale 1ns/1ps
// three-stage synchroniser, change accepted when stages two and three agree
module bfcu_sync (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic d_i,
    output logic q_o
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    // shift chain
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else begin
            s1_r <= d_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end
    // accepted level
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            q_o <= 1'b0;
        end else if (s2_r == s3_r) begin
            q_o <= s3_r;
        end
    end
endmodule

// file: design/bfcu_ptr.sv
`timescale 1ns/1ps
// one fifo's pointer set: primary pointer plus its saved replay copy
module bfcu_ptr (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic clr_i,
    input wire logic save_i,
    input wire logic load_i,
    input wire logic inc_i,
    output logic [bfcu_pkg::PTR_W-1:0] ptr_o,
    output logic [bfcu_pkg::PTR_W-1:0] saved_o
);
    // pointer and saved copy update
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || clr_i) begin
            ptr_o <= '0;
            saved_o <= '0;
        end else begin
            if (save_i) begin
                saved_o <= ptr_o;
            end
            if (load_i) begin
                ptr_o <= saved_o;
            end else if (inc_i) begin
                ptr_o <= ptr_o + 1'b1;
            end
        end
    end
endmodule

// file: design/bfcu_top.sv
`timescale 1ns/1ps
// command decoder and configuration bank of a dual-direction fifo
module bfcu_top (
    input wire logic REF_CLK_I,
    input wire logic RST_N_I,
    input wire logic PRIMARY_CHIP_SELECT_N_I,
    input wire logic PRIMARY_ADDR_HI_I,
    input wire logic PRIMARY_ADDR_LO_I,
    input wire logic PRIMARY_RD_WR_N_I,
    input wire logic PRIMARY_DATA_STROBE_N_I,
    input wire logic [15:0] PRIMARY_DATA_I,
    output logic [15:0] PRIMARY_DATA_O,
    output logic PRIMARY_DATA_OE_O,
    input wire logic [7:0] INTERNAL_FLAGS_I,
    output logic [3:0] EXTERNAL_FLAG_PINS_O,
    input wire logic [5:0] PROG_IO_PIN_I,
    output logic [5:0] PROG_IO_PIN_O,
    output logic [5:0] PROG_IO_PIN_OE_O,
    input wire logic DMA_CLK_I,
    input wire logic DMA_XFER_I,
    output logic DMA_REQ_O,
    input wire logic DMA_ACK_I,
    output logic DMA_ACK_O,
    output logic SECONDARY_READ_STROBE_N_O,
    output logic SECONDARY_WRITE_STROBE_N_O,
    output logic SECONDARY_DATA_STROBE_N_O,
    output logic SECONDARY_DIR_LINE_O,
    output logic SECONDARY_STROBE_OE_O,
    output logic FULL_USES_REREAD_O,
    output logic EMPTY_USES_REWRITE_O,
    output logic [9:0] FWD_ALMOST_EMPTY_O,
    output logic [9:0] FWD_ALMOST_FULL_O,
    output logic [9:0] REV_ALMOST_EMPTY_O,
    output logic [9:0] REV_ALMOST_FULL_O,
    output logic STATUS_FORMAT_O,
    output logic [9:0] FWD_READ_PTR_O,
    output logic [9:0] FWD_WRITE_PTR_O,
    output logic [9:0] FWD_REREAD_PTR_O,
    output logic [9:0] REV_READ_PTR_O,
    output logic [9:0] REV_WRITE_PTR_O,
    output logic [9:0] REV_REWRITE_PTR_O
);
    logic cs_n_s;
    logic a1_s;
    logic a0_s;
    logic rw_s;
    logic ds_n_s;
    logic clk_ext_s;
    logic xfer_s;
    logic ack_in_s;
    logic ds_n_d_r;
    logic [15:0] data_r;
    logic [15:0] data_d_r;
    logic [15:0] cfg_r [8];
    logic [2:0] cfg_sel_r;
    logic dma_dir_r;
    logic fmt_r;
    logic [3:0] opc;
    logic [2:0] opr;
    logic access;
    logic cmd_wr;
    logic cfg_wr;
    logic clr_fwd;
    logic clr_rev;
    logic clr_dma;
    logic clr_cfg;
    logic [15:0] gc;
    logic [15:0] pio_rd;
    logic [bfcu_pkg::PIO_N-1:0] pin_s;
    logic clk_ext_d_r;
    logic div_r;
    logic dma_tick;
    bfcu_pkg::bfcu_dma_t dma_st_r;
    logic [2:0] dma_cnt_r;
    logic dma_stb_r;
    logic [2:0] dly_clks;

    // primary port control and external dma pins are asynchronous
    bfcu_sync u_sync_cs (.clk_i(REF_CLK_I), .rst_n_i(RST_N_I), .d_i(PRIMARY_CHIP_SELECT_N_I), .q_o(cs_n_s));
    bfcu_sync u_sync_a1 (.clk_i(REF_CLK_I), .rst_n_i(RST_N_I), .d_i(PRIMARY_ADDR_HI_I), .q_o(a1_s));
    bfcu_sync u_sync_a0 (.clk_i(REF_CLK_I), .rst_n_i(RST_N_I), .d_i(PRIMARY_ADDR_LO_I), .q_o(a0_s));
    bfcu_sync u_sync_rw (.clk_i(REF_CLK_I), .rst_n_i(RST_N_I), .d_i(PRIMARY_RD_WR_N_I), .q_o(rw_s));
    bfcu_sync u_sync_ds (.clk_i(REF_CLK_I), .rst_n_i(RST_N_I), .d_i(PRIMARY_DATA_STROBE_N_I), .q_o(ds_n_s));
    bfcu_sync u_sync_ck (.clk_i(REF_CLK_I), .rst_n_i(RST_N_I), .d_i(DMA_CLK_I), .q_o(clk_ext_s));
    bfcu_sync u_sync_xf (.clk_i(REF_CLK_I), .rst_n_i(RST_N_I), .d_i(DMA_XFER_I), .q_o(xfer_s));
    bfcu_sync u_sync_ak (.clk_i(REF_CLK_I), .rst_n_i(RST_N_I), .d_i(DMA_ACK_I), .q_o(ack_in_s));
    // io pins are asynchronous as well, one synchroniser per pin
    for (genvar g = 0; g < bfcu_pkg::PIO_N; g++) begin : g_pin_sync
        bfcu_sync u_sync_pin (.clk_i(REF_CLK_I), .rst_n_i(RST_N_I), .d_i(PROG_IO_PIN_I[g]), .q_o(pin_s[g]));
    end

    // data bus is registered two deep, shallower than the strobe path
    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            data_d_r <= 16'h0000;
            data_r <= 16'h0000;
            ds_n_d_r <= 1'b0; // no false strobe fall while the synchronisers refill
        end else begin
            data_d_r <= PRIMARY_DATA_I;
            data_r <= data_d_r;
            ds_n_d_r <= ds_n_s;
        end
    end

    // strobe falling edge marks one access
    assign access = ds_n_d_r && !ds_n_s && !cs_n_s;
    assign cmd_wr = access && a1_s && a0_s && !rw_s;
    assign cfg_wr = access && a1_s && !a0_s && !rw_s;
    assign opc = data_r[bfcu_pkg::OPC_LSB +: 4];
    assign opr = data_r[2:0];
    assign gc = cfg_r[5];

    // software reset decode
    assign clr_rev = cmd_wr && opc == bfcu_pkg::OP_RESET
        && (opr == bfcu_pkg::RST_REV || opr == bfcu_pkg::RST_BOTH || opr == bfcu_pkg::RST_ALL);
    assign clr_fwd = cmd_wr && opc == bfcu_pkg::OP_RESET
        && (opr == bfcu_pkg::RST_FWD || opr == bfcu_pkg::RST_BOTH || opr == bfcu_pkg::RST_ALL);
    assign clr_dma = cmd_wr && opc == bfcu_pkg::OP_RESET
        && (opr == bfcu_pkg::RST_DMA || opr == bfcu_pkg::RST_ALL);
    assign clr_cfg = cmd_wr && opc == bfcu_pkg::OP_RESET && opr == bfcu_pkg::RST_ALL;

    // forward fifo: secondary side reads, reread copy
    bfcu_ptr u_fwd_rd (
        .clk_i(REF_CLK_I), .rst_n_i(RST_N_I), .clr_i(clr_fwd),
        .save_i(cmd_wr && opc == bfcu_pkg::OP_SAVE_RD),
        .load_i(cmd_wr && opc == bfcu_pkg::OP_LOAD_RD),
        .inc_i(cmd_wr && opc == bfcu_pkg::OP_INC_RD),
        .ptr_o(FWD_READ_PTR_O), .saved_o(FWD_REREAD_PTR_O)
    );
    bfcu_ptr u_fwd_wr (
        .clk_i(REF_CLK_I), .rst_n_i(RST_N_I), .clr_i(clr_fwd),
        .save_i(1'b0), .load_i(1'b0), .inc_i(1'b0),
        .ptr_o(FWD_WRITE_PTR_O), .saved_o()
    );
    // reverse fifo: secondary side writes, rewrite copy
    bfcu_ptr u_rev_wr (
        .clk_i(REF_CLK_I), .rst_n_i(RST_N_I), .clr_i(clr_rev),
        .save_i(cmd_wr && opc == bfcu_pkg::OP_SAVE_WR),
        .load_i(cmd_wr && opc == bfcu_pkg::OP_LOAD_WR),
        .inc_i(cmd_wr && opc == bfcu_pkg::OP_INC_WR),
        .ptr_o(REV_WRITE_PTR_O), .saved_o(REV_REWRITE_PTR_O)
    );
    bfcu_ptr u_rev_rd (
        .clk_i(REF_CLK_I), .rst_n_i(RST_N_I), .clr_i(clr_rev),
        .save_i(1'b0), .load_i(1'b0), .inc_i(1'b0),
        .ptr_o(REV_READ_PTR_O), .saved_o()
    );

    // configuration select; reserved opcodes fall through untouched
    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            cfg_sel_r <= 3'h0;
        end else if (cmd_wr && opc == bfcu_pkg::OP_SEL_CFG) begin
            cfg_sel_r <= opr;
        end
    end

    // dma direction and status format: hardware reset only
    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            dma_dir_r <= 1'b0;
            fmt_r <= 1'b0;
        end else if (cmd_wr && opc == bfcu_pkg::OP_DMA_DIR && gc[bfcu_pkg::GC_PERIPH]) begin
            dma_dir_r <= opr[0];
        end
    end

    // configuration bank write and defaults
    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I || clr_cfg) begin
            for (int i = 0; i < 8; i++) begin
                cfg_r[i] <= (i == 4) ? bfcu_pkg::CFG4_RESET : bfcu_pkg::CFG_RESET;
            end
        end else if (cfg_wr) begin
            cfg_r[cfg_sel_r] <= data_r;
        end
    end

    // almost offsets are ten bits wide
    assign FWD_ALMOST_EMPTY_O = cfg_r[0][9:0];
    assign FWD_ALMOST_FULL_O = cfg_r[1][9:0];
    assign REV_ALMOST_EMPTY_O = cfg_r[2][9:0];
    assign REV_ALMOST_FULL_O = cfg_r[3][9:0];
    assign FULL_USES_REREAD_O = gc[bfcu_pkg::GC_FULL_DEF];
    assign EMPTY_USES_REWRITE_O = gc[bfcu_pkg::GC_EMPTY_DEF];
    assign STATUS_FORMAT_O = fmt_r;

    // flag pin routing: low three code bits pick the internal flag
    always_comb begin
        for (int p = 0; p < 4; p++) begin
            EXTERNAL_FLAG_PINS_O[p] = INTERNAL_FLAGS_I[cfg_r[4][4*p +: 3]];
        end
    end

    // programmable io pins
    assign PROG_IO_PIN_OE_O = cfg_r[7][5:0];
    assign PROG_IO_PIN_O = cfg_r[6][5:0];
    always_comb begin
        pio_rd = cfg_r[6];
        for (int k = 0; k < bfcu_pkg::PIO_N; k++) begin
            if (!cfg_r[7][k]) begin
                pio_rd[k] = pin_s[k];
            end
        end
    end

    // read data register for configuration and status reads
    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            PRIMARY_DATA_O <= 16'h0000;
        end else if (!cs_n_s && rw_s && a1_s) begin
            if (a0_s) begin
                PRIMARY_DATA_O <= {INTERNAL_FLAGS_I[5], INTERNAL_FLAGS_I[4], INTERNAL_FLAGS_I[3],
                    INTERNAL_FLAGS_I[2], 4'h0, INTERNAL_FLAGS_I[7], INTERNAL_FLAGS_I[6],
                    INTERNAL_FLAGS_I[1], INTERNAL_FLAGS_I[0], dma_dir_r, 3'h0};
            end else if (cfg_sel_r == 3'h6) begin
                PRIMARY_DATA_O <= pio_rd;
            end else begin
                PRIMARY_DATA_O <= cfg_r[cfg_sel_r];
            end
        end
    end
    assign PRIMARY_DATA_OE_O = !cs_n_s && rw_s && a1_s && !ds_n_s;

    // internal dma clock tick from the external clock, optionally halved
    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            clk_ext_d_r <= 1'b0;
            div_r <= 1'b0;
        end else begin
            clk_ext_d_r <= clk_ext_s;
            if (clk_ext_s && !clk_ext_d_r) begin
                div_r <= !div_r;
            end
        end
    end
    assign dma_tick = clk_ext_s && !clk_ext_d_r && (!gc[bfcu_pkg::GC_CLK_DIV] || div_r);
    assign dly_clks = bfcu_pkg::DLY_BASE + {1'b0, gc[bfcu_pkg::GC_DLY_LSB +: 2]};

    // dma request sequencer, active only in peripheral mode
    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I || clr_dma || !gc[bfcu_pkg::GC_PERIPH]) begin
            dma_st_r <= bfcu_pkg::DMA_IDLE;
            dma_cnt_r <= 3'h0;
            dma_stb_r <= 1'b0;
        end else if (dma_tick) begin
            case (dma_st_r)
                bfcu_pkg::DMA_IDLE: begin
                    if (xfer_s) begin
                        dma_st_r <= bfcu_pkg::DMA_WAIT;
                        dma_cnt_r <= 3'h0;
                    end
                end
                bfcu_pkg::DMA_WAIT: begin
                    if (dma_cnt_r >= dly_clks && ack_in_s) begin // ack shown before the strobe
                        dma_st_r <= bfcu_pkg::DMA_STROBE;
                        dma_cnt_r <= 3'h0;
                        dma_stb_r <= 1'b1;
                    end else if (dma_cnt_r < dly_clks) begin
                        dma_cnt_r <= dma_cnt_r + 3'h1;
                    end
                end
                bfcu_pkg::DMA_STROBE: begin
                    if (dma_cnt_r >= {2'b00, gc[bfcu_pkg::GC_STB_LEN]}) begin
                        dma_st_r <= bfcu_pkg::DMA_IDLE;
                        dma_stb_r <= 1'b0;
                        dma_cnt_r <= 3'h0;
                    end else begin
                        dma_cnt_r <= dma_cnt_r + 3'h1;
                    end
                end
                default: begin
                    dma_st_r <= bfcu_pkg::DMA_IDLE;
                end
            endcase
        end
    end

    // request and acknowledge with programmable polarity
    assign DMA_REQ_O = (dma_st_r != bfcu_pkg::DMA_IDLE && gc[bfcu_pkg::GC_PERIPH]) ^ gc[bfcu_pkg::GC_REQ_POL];
    assign DMA_ACK_O = (dma_st_r == bfcu_pkg::DMA_WAIT && dma_cnt_r >= dly_clks) ^ gc[bfcu_pkg::GC_ACK_POL];
    // secondary strobes in the selected style
    assign SECONDARY_STROBE_OE_O = gc[bfcu_pkg::GC_PERIPH];
    assign SECONDARY_READ_STROBE_N_O = !(dma_stb_r && !gc[bfcu_pkg::GC_STROBE] && dma_dir_r);
    assign SECONDARY_WRITE_STROBE_N_O = !(dma_stb_r && !gc[bfcu_pkg::GC_STROBE] && !dma_dir_r);
    assign SECONDARY_DATA_STROBE_N_O = !(dma_stb_r && gc[bfcu_pkg::GC_STROBE]);
    assign SECONDARY_DIR_LINE_O = dma_dir_r;
endmodule

// file: testbench/bfcu_monitor.sv
`timescale 1ns/1ps
// port-level checker for the command decoder and configuration bank
module bfcu_monitor (
    input wire logic REF_CLK_I,
    input wire logic RST_N_I,
    input wire logic PRIMARY_CHIP_SELECT_N_I,
    input wire logic PRIMARY_ADDR_HI_I,
    input wire logic PRIMARY_RD_WR_N_I,
    input wire logic PRIMARY_DATA_STROBE_N_I,
    input wire logic PRIMARY_DATA_OE_O,
    input wire logic [9:0] FWD_ALMOST_EMPTY_O,
    input wire logic FULL_USES_REREAD_O,
    input wire logic [5:0] PROG_IO_PIN_O,
    input wire logic SECONDARY_STROBE_OE_O,
    input wire logic SECONDARY_DIR_LINE_O,
    input wire logic STATUS_FORMAT_O,
    input wire logic [9:0] FWD_READ_PTR_O,
    input wire logic [9:0] FWD_WRITE_PTR_O,
    input wire logic [9:0] FWD_REREAD_PTR_O,
    input wire logic [9:0] REV_READ_PTR_O,
    input wire logic [9:0] REV_WRITE_PTR_O,
    input wire logic [9:0] REV_REWRITE_PTR_O
);
    logic [3:0] wr_age_r;
    logic [3:0] rd_age_r;
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RST_N_I);
    // cycles since the host last held a write or a register read on the pins, saturating
    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) wr_age_r <= 4'hf;
        else if (!PRIMARY_CHIP_SELECT_N_I && !PRIMARY_RD_WR_N_I && !PRIMARY_DATA_STROBE_N_I) wr_age_r <= 4'h0;
        else if (wr_age_r != 4'hf) wr_age_r <= wr_age_r + 4'h1;
    end
    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) rd_age_r <= 4'hf;
        else if (!PRIMARY_CHIP_SELECT_N_I && PRIMARY_ADDR_HI_I && PRIMARY_RD_WR_N_I) rd_age_r <= 4'h0;
        else if (rd_age_r != 4'hf) rd_age_r <= rd_age_r + 4'h1;
    end
    property p_fwd_rd;
        $changed(FWD_READ_PTR_O) |-> FWD_READ_PTR_O == $past(FWD_READ_PTR_O) + 10'h001
            || FWD_READ_PTR_O == 10'h000 || FWD_READ_PTR_O == $past(FWD_REREAD_PTR_O);
    endproperty
    a_fwd_rd: assert property (p_fwd_rd) else $error("forward read pointer moved wrongly");
    property p_rev_wr;
        $changed(REV_WRITE_PTR_O) |-> REV_WRITE_PTR_O == $past(REV_WRITE_PTR_O) + 10'h001
            || REV_WRITE_PTR_O == 10'h000 || REV_WRITE_PTR_O == $past(REV_REWRITE_PTR_O);
    endproperty
    a_rev_wr: assert property (p_rev_wr) else $error("reverse write pointer moved wrongly");
    property p_reread;
        $changed(FWD_REREAD_PTR_O) |-> FWD_REREAD_PTR_O == 10'h000 || FWD_REREAD_PTR_O == $past(FWD_READ_PTR_O);
    endproperty
    a_reread: assert property (p_reread) else $error("reread pointer took a wrong value");
    property p_rewrite;
        $changed(REV_REWRITE_PTR_O) |-> REV_REWRITE_PTR_O == 10'h000 || REV_REWRITE_PTR_O == $past(REV_WRITE_PTR_O);
    endproperty
    a_rewrite: assert property (p_rewrite) else $error("rewrite pointer took a wrong value");
    property p_ptr_cause;
        $changed({FWD_READ_PTR_O, FWD_WRITE_PTR_O, REV_READ_PTR_O, REV_WRITE_PTR_O}) |-> wr_age_r < 4'ha;
    endproperty
    a_ptr_cause: assert property (p_ptr_cause) else $error("pointer moved without a write");
    property p_cfg_cause;
        $changed({FWD_ALMOST_EMPTY_O, FULL_USES_REREAD_O, PROG_IO_PIN_O, SECONDARY_STROBE_OE_O}) |-> wr_age_r < 4'ha;
    endproperty
    a_cfg_cause: assert property (p_cfg_cause) else $error("configuration moved without a write");
    property p_dir;
        $changed(SECONDARY_DIR_LINE_O) |-> $past(SECONDARY_STROBE_OE_O) && wr_age_r < 4'ha;
    endproperty
    a_dir: assert property (p_dir) else $error("direction changed outside peripheral mode");
    property p_fmt;
        STATUS_FORMAT_O == 1'b0;
    endproperty
    a_fmt: assert property (p_fmt) else $error("status format not cleared");
    property p_oe;
        PRIMARY_DATA_OE_O |-> rd_age_r < 4'h8;
    endproperty
    a_oe: assert property (p_oe) else $error("data driven without a register read");
    c_inc: cover property (FWD_READ_PTR_O == $past(FWD_READ_PTR_O) + 10'h001 && $changed(FWD_READ_PTR_O));
    c_dir: cover property ($rose(SECONDARY_DIR_LINE_O));
    c_oe: cover property ($rose(PRIMARY_DATA_OE_O));
endmodule
bind bfcu_top bfcu_monitor i_mon (.REF_CLK_I, .RST_N_I, .PRIMARY_CHIP_SELECT_N_I, .PRIMARY_ADDR_HI_I,
    .PRIMARY_RD_WR_N_I, .PRIMARY_DATA_STROBE_N_I, .PRIMARY_DATA_OE_O, .FWD_ALMOST_EMPTY_O, .FULL_USES_REREAD_O,
    .PROG_IO_PIN_O, .SECONDARY_STROBE_OE_O, .SECONDARY_DIR_LINE_O, .STATUS_FORMAT_O, .FWD_READ_PTR_O,
    .FWD_WRITE_PTR_O, .FWD_REREAD_PTR_O, .REV_READ_PTR_O, .REV_WRITE_PTR_O, .REV_REWRITE_PTR_O);

// file: testbench/bfcu_host.sv
`timescale 1ns/1ps
// host on the primary port: one register access per call, spaced for the synchroniser
module bfcu_host (
    input wire logic clk_i,
    input wire logic [15:0] data_i,
    output logic cs_n_o,
    output logic a1_o,
    output logic a0_o,
    output logic rd_wr_n_o,
    output logic ds_n_o,
    output logic [15:0] data_o,
    output logic rv_o,
    output logic [15:0] q_o
);
    // idle bus, strobe and select high
    initial begin
        cs_n_o = 1'b1;
        a1_o = 1'b0;
        a0_o = 1'b0;
        rd_wr_n_o = 1'b1;
        ds_n_o = 1'b1;
        data_o = 16'h0000;
        rv_o = 1'b0;
        q_o = 16'h0000;
    end
    // strobe held low eight clocks, read data taken at the last edge, then eight idle clocks
    task automatic xfer(input logic rd, input logic a0v, input logic [15:0] d);
        @(negedge clk_i);
        cs_n_o = 1'b0;
        a1_o = 1'b1;
        a0_o = a0v;
        rd_wr_n_o = rd;
        ds_n_o = 1'b0;
        data_o = rd ? ~data_o : d;
        repeat (8) @(posedge clk_i);
        q_o = data_i;
        rv_o = rd;
        @(negedge clk_i);
        rv_o = 1'b0;
        cs_n_o = 1'b1;
        ds_n_o = 1'b1;
        data_o = ~data_o; // released bus does not keep its last value
        repeat (8) @(negedge clk_i);
    endtask
    task automatic wr(input logic a0v, input logic [15:0] d);
        xfer(1'b0, a0v, d);
    endtask
    task automatic rd(input logic a0v);
        xfer(1'b1, a0v, 16'h0000);
    endtask
endmodule

// file: testbench/bfcu_top_tb.sv
`timescale 1ns/1ps
// self-checking bench for the command decoder and configuration bank
module bfcu_top_tb;
    localparam logic [15:0] MK [8] = '{16'h03ff, 16'h03ff, 16'h03ff, 16'h03ff, 16'hffff, 16'h07fd, 16'h003f, 16'hffff};
    localparam logic [6:0] SQ [31] = '{7'h40, 7'h40, 7'h40, 7'h10, 7'h40, 7'h40, 7'h48, 7'h48, 7'h18, 7'h48,
        7'h38, 7'h55, 7'h5b, 7'h60, 7'h7f, 7'h00, 7'h05, 7'h06, 7'h20, 7'h28, 7'h31, 7'h04, 7'h02, 7'h40,
        7'h48, 7'h01, 7'h48, 7'h40, 7'h03, 7'h40, 7'h18};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] flags = 8'h00;
    logic [5:0] pin = 6'h00;
    logic cs_n, a1, a0, rw_n, ds_n, rv, fur, eur, soe, dir, fmt, dreq, dack, srd, swr, sds;
    logic [15:0] wd, dout, q;
    logic [3:0] ext;
    logic [5:0] pio_o, pio_oe;
    logic [9:0] fae, faf, rae, raf, fr, fw, frr, rr, rw, rrw;
    logic [9:0] e [4];
    logic [15:0] v [8];
    logic [31:0] exq [$];
    logic [31:0] ent;
    logic [31:0] seed;
    logic pm, edir;
    int err_total = 0;
    int total_checks = 0;
    bfcu_host i_host (.clk_i(clk), .data_i(dout), .cs_n_o(cs_n), .a1_o(a1), .a0_o(a0), .rd_wr_n_o(rw_n),
        .ds_n_o(ds_n), .data_o(wd), .rv_o(rv), .q_o(q));
    bfcu_top i_bfcu_top (.REF_CLK_I(clk), .RST_N_I(rst_n), .PRIMARY_CHIP_SELECT_N_I(cs_n), .PRIMARY_ADDR_HI_I(a1),
        .PRIMARY_ADDR_LO_I(a0), .PRIMARY_RD_WR_N_I(rw_n), .PRIMARY_DATA_STROBE_N_I(ds_n), .PRIMARY_DATA_I(wd),
        .PRIMARY_DATA_O(dout), .PRIMARY_DATA_OE_O(), .INTERNAL_FLAGS_I(flags), .EXTERNAL_FLAG_PINS_O(ext),
        .PROG_IO_PIN_I(pin), .PROG_IO_PIN_O(pio_o), .PROG_IO_PIN_OE_O(pio_oe), .DMA_CLK_I(1'b0), .DMA_XFER_I(1'b0),
        .DMA_REQ_O(dreq), .DMA_ACK_I(1'b0), .DMA_ACK_O(dack), .SECONDARY_READ_STROBE_N_O(srd),
        .SECONDARY_WRITE_STROBE_N_O(swr), .SECONDARY_DATA_STROBE_N_O(sds), .SECONDARY_DIR_LINE_O(dir),
        .SECONDARY_STROBE_OE_O(soe),
        .FULL_USES_REREAD_O(fur), .EMPTY_USES_REWRITE_O(eur), .FWD_ALMOST_EMPTY_O(fae), .FWD_ALMOST_FULL_O(faf),
        .REV_ALMOST_EMPTY_O(rae), .REV_ALMOST_FULL_O(raf), .STATUS_FORMAT_O(fmt), .FWD_READ_PTR_O(fr),
        .FWD_WRITE_PTR_O(fw), .FWD_REREAD_PTR_O(frr), .REV_READ_PTR_O(rr), .REV_WRITE_PTR_O(rw),
        .REV_REWRITE_PTR_O(rrw));
    initial begin
        forever #4 clk = ~clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic chk(input logic [63:0] s, input logic [63:0] x);
        total_checks++;
        if (s !== x) begin
            err_total++;
            $display("mismatch at %0t: got %h want %h", $time, s, x);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // command word with junk in the ignored bits
    task automatic cmd(input logic [3:0] c, input logic [2:0] o);
        seed = lfsr(seed);
        i_host.wr(1'b1, (seed[15:0] & 16'hf0f8) | {4'h0, c, 5'h00, o});
    endtask
    task automatic rdx(input logic a0v, input logic [15:0] m, input logic [15:0] x);
        exq.push_back({m, x & m});
        i_host.rd(a0v);
    endtask
    task automatic cfgw(input logic [2:0] n, input logic [15:0] d);
        cmd(4'h1, n);
        i_host.wr(1'b0, d);
        if (n == 3'h5) pm = d[10];
    endtask
    task automatic cfgr(input logic [2:0] n, input logic [15:0] x);
        cmd(4'h1, n);
        rdx(1'b0, MK[n], x);
    endtask
    task automatic route(input logic [15:0] r);
        for (int k = 0; k < 4; k++) chk(64'(ext[k]), 64'(flags[r[4*k+:3]]));
    endtask
    task automatic status();
        rdx(1'b1, 16'hf0f8, {flags[5:2], 4'h0, flags[7:6], flags[1:0], edir, 3'h0});
    endtask
    task automatic defaults();
        for (int i = 0; i < 8; i++) cfgr(i[2:0], i == 4 ? 16'h6420 : (i == 6 ? {10'h000, pin} : 16'h0000));
        route(16'h6420);
        chk(64'({pio_o, pio_oe, soe}), 64'h0);
    endtask
    // command plus the pointer and direction model it should produce
    task automatic op(input logic [3:0] c, input logic [2:0] o);
        cmd(c, o);
        case (c)
            4'h0: begin
                if (o == 3'h2 || o == 3'h3 || o == 3'h7) {e[0], e[1]} = 20'h0;
                if (o == 3'h1 || o == 3'h3 || o == 3'h7) {e[2], e[3]} = 20'h0;
                if (o == 3'h7) pm = 1'b0;
            end
            4'h2: e[1] = e[0];
            4'h3: e[3] = e[2];
            4'h4: e[0] = e[1];
            4'h5: e[2] = e[3];
            4'h6: if (pm) edir = o[0];
            4'h8: e[0] = e[0] + 10'h001;
            4'h9: e[2] = e[2] + 10'h001;
            default: ;
        endcase
        chk({4'h0, fr, fw, frr, rr, rw, rrw}, {4'h0, e[0], 10'h000, e[1], 10'h000, e[2], e[3]});
        chk(64'(dir), 64'(edir));
    endtask
    // read results checked in order against the oldest expectation
    always @(posedge rv) begin
        if (exq.size() == 0) chk(64'h1, 64'h0);
        else begin
            ent = exq.pop_front();
            chk(64'(q & ent[31:16]), 64'(ent[15:0]));
        end
    end
    initial begin
        repeat (100000) @(posedge clk);
        err_total++;
        summarize();
    end
    initial begin
        seed = 32'h05d5_33cc;
        {e[0], e[1], e[2], e[3]} = 40'h0;
        pm = 1'b0;
        edir = 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk) rst_n = 1'b1;
        repeat (4) @(negedge clk);
        pin = seed[5:0];
        flags = seed[15:8];
        defaults();
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            v[i] = seed[15:0];
            cfgw(i[2:0], v[i]);
        end
        seed = lfsr(seed);
        flags = seed[7:0];
        pin = seed[13:8];
        for (int i = 0; i < 8; i++) cfgr(i[2:0], i == 6 ? (v[6] & v[7]) | ({10'h000, pin} & ~v[7]) : v[i]);
        chk(64'({fae, faf, rae, raf}), 64'({v[0][9:0], v[1][9:0], v[2][9:0], v[3][9:0]}));
        chk(64'({pio_o, pio_oe}), 64'({v[6][5:0], v[7][5:0]}));
        chk(64'({fur, eur, soe}), 64'({v[5][2], v[5][3], v[5][10]}));
        chk(64'({dreq, dack, srd, swr, sds}), 64'({v[5][4], v[5][5], 3'h7}));
        route(v[4]);
        status();
        op(4'h0, 3'h7);
        defaults();
        for (int i = 0; i < 31; i++) op(SQ[i][6:3], SQ[i][2:0]);
        cfgw(3'h5, 16'h0400);
        chk(64'(soe), 64'h1);
        op(4'h6, 3'h1);
        status();
        op(4'h0, 3'h7);
        op(4'h6, 3'h0);
        status();
        @(negedge clk) rst_n = 1'b0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        edir = 1'b0;
        repeat (4) @(posedge clk);
        chk(64'(dir), 64'h0);
        defaults();
        chk(64'(exq.size()), 64'h0);
        summarize();
    end
endmodule
